// file: feeder_serial_command_port.v
// Purpose: framed text command port of a product feeder controller
// Assumes: one 100 MHz clock; counter events are same-clock pulses
// Notes:   a reply in progress causes new queries to be dropped
`timescale 1ns/10ps
`include "feeder_defs.vh"
// Operation
// - primary port rate selectable among seven rates 2400 to 115200
// - secondary port has its own independent rate setting
// - characters are 8 data bits, no parity, 1 stop, no flow control
// - the external connector is the primary port at its rate
// - key held at power-up dumps speed, batch, delay and the three counters, not the rates, on primary port
// - terminal can read the stored feeder settings over serial
// - mc! dc! tc! clear miss, double and job-batch counters
// - a new rate is stored only on enter; menu exit keeps the old
// - running totals of double and missed feeds are kept
module feeder_serial_command_port #(
    parameter CLK_HZ = `CLK_HZ
) (
    // clock and reset
    input  wire        core_clk,
    input  wire        rstn,
    // serial pins, primary is the external connector
    input  wire        prim_rxd,
    output wire        prim_txd,
    input  wire        sec_rxd,
    output wire        sec_txd,
    // operator menu for bit rates
    input  wire        menu_select,
    input  wire        menu_port,
    input  wire [2:0]  menu_rate,
    input  wire        menu_enter,
    input  wire        menu_exit,
    // cycle key pin
    input  wire        cycle_key,
    // feed events
    input  wire        miss_event,
    input  wire        double_event,
    input  wire        batch_done,
    // settings and commands to the feeder
    output reg  [6:0]  speed_reg,
    output reg  [13:0] batch_reg,
    output reg  [6:0]  delay_reg,
    output reg         trigger_reg,
    output reg         rstop_reg,
    output reg         feeder_reset_reg,
    output reg  [2:0]  prim_rate_reg,
    output reg  [2:0]  sec_rate_reg,
    output reg  [15:0] miss_cnt_reg,
    output reg  [15:0] double_cnt_reg,
    output reg  [15:0] jobs_cnt_reg
);
    localparam P_IDLE = 2'h0, P_BODY = 2'h1, P_ARG = 2'h2;
    localparam R_IDLE = 2'h0, R_TAG = 2'h1, R_DIG = 2'h2, R_CR = 2'h3;
    // bit period for a rate code; invalid codes never get stored
    function [15:0] rate_div;
        input [2:0]  sel;
        reg   [31:0] q;
        begin
            case (sel)
                `RATE_2400:  q = CLK_HZ / `BAUD_2400;
                `RATE_9600:  q = CLK_HZ / `BAUD_9600;
                `RATE_19200: q = CLK_HZ / `BAUD_19200;
                `RATE_28800: q = CLK_HZ / `BAUD_28800;
                `RATE_38400: q = CLK_HZ / `BAUD_38400;
                `RATE_57600: q = CLK_HZ / `BAUD_57600;
                default:     q = CLK_HZ / `BAUD_115200;
            endcase
            rate_div = q[15:0]; // slowest rate still fits at 100 MHz
        end
    endfunction

    // decimal weight of a digit position, most significant first
    function [15:0] weight;
        input [2:0] pos;
        begin
            case (pos)
                3'h0:    weight = 16'h2710;
                3'h1:    weight = 16'h03E8;
                3'h2:    weight = 16'h0064;
                3'h3:    weight = 16'h000A;
                default: weight = 16'h0001;
            endcase
        end
    endfunction

    wire [7:0] rx_data [0:1];
    wire       rx_valid [0:1];
    wire       tx_ready [0:1];
    reg  [7:0] tx_data_reg;
    reg  [1:0] tx_go_reg;

    // each port has its own uart_link instance; each runs at its own rate
    uart_link u_prim (
        .core_clk     (core_clk),
        .rstn         (rstn),
        .bit_div      (rate_div(prim_rate_reg)),
        .rxd          (prim_rxd),
        .txd_reg      (prim_txd),
        .rx_data_reg  (rx_data[0]),
        .rx_valid_reg (rx_valid[0]),
        .tx_data      (tx_data_reg),
        .tx_valid     (tx_go_reg[0]),
        .tx_ready_reg (tx_ready[0])
    );
    uart_link u_sec (
        .core_clk     (core_clk),
        .rstn         (rstn),
        .bit_div      (rate_div(sec_rate_reg)),
        .rxd          (sec_rxd),
        .txd_reg      (sec_txd),
        .rx_data_reg  (rx_data[1]),
        .rx_valid_reg (rx_valid[1]),
        .tx_data      (tx_data_reg),
        .tx_valid     (tx_go_reg[1]),
        .tx_ready_reg (tx_ready[1])
    );

    // rate menu: a pick is held pending until enter or exit
    reg       pend_reg;
    reg       pend_port_reg;
    reg [2:0] pend_rate_reg;
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pend_reg      <= 1'b0;
            pend_port_reg <= 1'b0;
            pend_rate_reg <= `RATE_DEFAULT;
            prim_rate_reg <= `RATE_DEFAULT;
            sec_rate_reg  <= `RATE_DEFAULT;
        end else if (menu_exit) begin
            pend_reg <= 1'b0; // old rate kept
        end else if (menu_enter && pend_reg) begin
            pend_reg <= 1'b0;
            if (pend_port_reg)
                sec_rate_reg <= pend_rate_reg;
            else
                prim_rate_reg <= pend_rate_reg;
        end else if (menu_select && menu_rate <= `RATE_115200) begin
            pend_reg      <= 1'b1;
            pend_port_reg <= menu_port;
            pend_rate_reg <= menu_rate;
        end
    end

    // frame parser; the port whose stx came last owns the frame
    reg  [1:0]  p_state_reg;
    reg         p_port_reg;
    reg  [1:0]  p_pos_reg;
    reg  [7:0]  c0_reg;
    reg  [7:0]  c1_reg;
    reg  [7:0]  c2_reg;
    reg  [13:0] num_reg;
    reg  [2:0]  ndig_reg;
    reg         exec_reg;
    wire        rx_port = rx_valid[0] ? 1'b0 : 1'b1;
    wire        rx_any = rx_valid[0] | rx_valid[1];
    wire [7:0]  rx_ch = rx_valid[0] ? rx_data[0] : rx_data[1];
    wire        is_dig = rx_ch >= `CH_ZERO && rx_ch <= `CH_NINE;
    wire        mine = rx_any && rx_port == p_port_reg;
    wire        has_arg = c0_reg == `CH_S || c0_reg == `CH_B ||
                          c0_reg == `CH_D;
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            p_state_reg <= P_IDLE;
            p_port_reg  <= 1'b0;
            p_pos_reg   <= 2'h0;
            c0_reg      <= 8'h00;
            c1_reg      <= 8'h00;
            c2_reg      <= 8'h00;
            num_reg     <= 14'h0000;
            ndig_reg    <= 3'h0;
            exec_reg    <= 1'b0;
        end else begin
            exec_reg <= 1'b0;
            if (rx_any && rx_ch == `CH_STX) begin
                p_state_reg <= P_BODY; // stx always restarts
                p_port_reg  <= rx_port;
                p_pos_reg   <= 2'h0;
                c1_reg      <= 8'h00;
                c2_reg      <= 8'h00;
                num_reg     <= 14'h0000;
                ndig_reg    <= 3'h0;
            end else if (mine && p_state_reg != P_IDLE) begin
                if (rx_ch == `CH_CR) begin
                    p_state_reg <= P_IDLE;
                    exec_reg    <= 1'b1;
                end else if (p_state_reg == P_ARG) begin
                    if (is_dig && ndig_reg < `MAX_DIGITS) begin
                        num_reg  <= num_reg * 14'h000A +
                                    {6'h00, rx_ch - `CH_ZERO};
                        ndig_reg <= ndig_reg + 3'h1;
                    end else begin
                        p_state_reg <= P_IDLE; // malformed
                    end
                end else if (p_pos_reg == 2'h0) begin
                    c0_reg    <= rx_ch;
                    p_pos_reg <= 2'h1;
                end else if (p_pos_reg == 2'h1) begin
                    c1_reg    <= rx_ch;
                    p_pos_reg <= 2'h2;
                    if (has_arg && rx_ch == `CH_SET)
                        p_state_reg <= P_ARG;
                end else if (p_pos_reg == 2'h2) begin
                    c2_reg    <= rx_ch;
                    p_pos_reg <= 2'h3;
                end else begin
                    p_state_reg <= P_IDLE; // too long
                end
            end
        end
    end

    // command decode at cr
    wire two    = p_pos_reg == 2'h2;
    wire cnt_op = p_pos_reg == 2'h3 && c1_reg == `CH_C;
    wire set_ok = has_arg && two && ndig_reg != 3'h0 && c1_reg == `CH_SET;
    wire do_clr = exec_reg && cnt_op && c2_reg == `CH_SET;
    wire do_rd  = exec_reg && cnt_op && c2_reg == `CH_QRY;
    wire do_qry = exec_reg && two && c0_reg == `CH_QRY &&
                  c1_reg == `CH_SET;
    wire do_one = exec_reg && two && c1_reg == `CH_SET;

    // settings and one-cycle command strobes
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            speed_reg        <= `SPEED_RST;
            batch_reg        <= `BATCH_RST;
            delay_reg        <= `DELAY_RST;
            trigger_reg      <= 1'b0;
            rstop_reg        <= 1'b0;
            feeder_reset_reg <= 1'b0;
        end else begin
            trigger_reg      <= do_one && c0_reg == `CH_T;
            rstop_reg        <= do_one && c0_reg == `CH_R;
            feeder_reset_reg <= do_one && c0_reg == `CH_F;
            if (exec_reg && set_ok) begin
                // out-of-range arguments leave the value alone
                if (c0_reg == `CH_S && num_reg >= `SPEED_MIN &&
                    num_reg <= `SPEED_MAX)
                    speed_reg <= num_reg[6:0];
                if (c0_reg == `CH_B && num_reg >= `BATCH_MIN &&
                    num_reg <= `BATCH_MAX)
                    batch_reg <= num_reg;
                if (c0_reg == `CH_D && num_reg <= `DELAY_MAX)
                    delay_reg <= num_reg[6:0];
            end
        end
    end

    // running totals; an event in the clear cycle still counts
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            miss_cnt_reg   <= 16'h0000;
            double_cnt_reg <= 16'h0000;
            jobs_cnt_reg   <= 16'h0000;
        end else begin
            if (do_clr && c0_reg == `CH_M)
                miss_cnt_reg <= {15'h0000, miss_event};
            else if (miss_event)
                miss_cnt_reg <= miss_cnt_reg + 16'h0001;
            if (do_clr && c0_reg == `CH_D)
                double_cnt_reg <= {15'h0000, double_event};
            else if (double_event)
                double_cnt_reg <= double_cnt_reg + 16'h0001;
            if (do_clr && c0_reg == `CH_T)
                jobs_cnt_reg <= {15'h0000, batch_done};
            else if (batch_done)
                jobs_cnt_reg <= jobs_cnt_reg + 16'h0001;
        end
    end

    // cycle key: synchronised, sampled once after reset settles
    reg       key_s1_reg;
    reg       key_s2_reg;
    reg [2:0] settle_reg;
    reg       dump_reg;
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            key_s1_reg <= 1'b0;
            key_s2_reg <= 1'b0;
            settle_reg <= 3'h0;
            dump_reg   <= 1'b0;
        end else begin
            key_s1_reg <= cycle_key;
            key_s2_reg <= key_s1_reg;
            dump_reg   <= 1'b0;
            if (settle_reg != `KEY_SETTLE) begin
                settle_reg <= settle_reg + 3'h1;
                dump_reg   <= settle_reg == `KEY_SETTLE - 3'h1 &&
                              key_s2_reg;
            end
        end
    end

    // reply: fields as tag plus five digits, closed by cr
    reg  [1:0]  r_state_reg;
    reg         r_port_reg;
    reg  [2:0]  fld_reg;
    reg  [2:0]  last_reg;
    reg  [2:0]  pos_reg;
    reg  [15:0] val_reg;
    reg  [3:0]  dig_reg;
    reg  [7:0]  tag;
    reg  [15:0] fval;
    wire        ready = tx_ready[r_port_reg] && tx_go_reg == 2'h0;
    always @* begin
        case (fld_reg)
            `FLD_SPEED:  begin tag = `CH_S; fval = {9'h000, speed_reg}; end
            `FLD_BATCH:  begin tag = `CH_B; fval = {2'h0, batch_reg}; end
            `FLD_DELAY:  begin tag = `CH_D; fval = {9'h000, delay_reg}; end
            `FLD_MISS:   begin tag = `CH_M; fval = miss_cnt_reg; end
            `FLD_DOUBLE: begin tag = `CH_K; fval = double_cnt_reg; end
            default:     begin tag = `CH_T; fval = jobs_cnt_reg; end
        endcase
    end
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            r_state_reg <= R_IDLE;
            r_port_reg  <= 1'b0;
            fld_reg     <= `FLD_SPEED;
            last_reg    <= `FLD_SPEED;
            pos_reg     <= 3'h0;
            val_reg     <= 16'h0000;
            dig_reg     <= 4'h0;
            tx_data_reg <= 8'h00;
            tx_go_reg   <= 2'h0;
        end else begin
            tx_go_reg <= 2'h0;
            case (r_state_reg)
                R_IDLE: begin
                    r_state_reg <= R_TAG;
                    if (dump_reg) begin
                        r_port_reg <= 1'b0;
                        fld_reg    <= `FLD_SPEED;
                        last_reg   <= `FLD_JOBS;
                    end else if (do_qry) begin
                        r_port_reg <= p_port_reg;
                        fld_reg    <= `FLD_SPEED;
                        last_reg   <= `FLD_DELAY;
                    end else if (do_rd && (c0_reg == `CH_M ||
                             c0_reg == `CH_D || c0_reg == `CH_T)) begin
                        r_port_reg <= p_port_reg;
                        fld_reg    <= c0_reg == `CH_M ? `FLD_MISS :
                                      c0_reg == `CH_D ? `FLD_DOUBLE :
                                      `FLD_JOBS;
                        last_reg   <= c0_reg == `CH_M ? `FLD_MISS :
                                      c0_reg == `CH_D ? `FLD_DOUBLE :
                                      `FLD_JOBS;
                    end else begin
                        r_state_reg <= R_IDLE;
                    end
                end
                R_TAG: if (ready) begin
                    tx_data_reg <= tag;
                    tx_go_reg[r_port_reg] <= 1'b1;
                    val_reg     <= fval; // value snapshot per field
                    pos_reg     <= 3'h0;
                    dig_reg     <= 4'h0;
                    r_state_reg <= R_DIG;
                end
                R_DIG: begin
                    // repeated subtraction: at most nine steps a digit
                    if (val_reg >= weight(pos_reg)) begin
                        val_reg <= val_reg - weight(pos_reg);
                        dig_reg <= dig_reg + 4'h1;
                    end else if (ready) begin
                        tx_data_reg <= `CH_ZERO + {4'h0, dig_reg};
                        tx_go_reg[r_port_reg] <= 1'b1;
                        dig_reg <= 4'h0;
                        pos_reg <= pos_reg + 3'h1;
                        if (pos_reg == `LAST_DIGIT) begin
                            fld_reg     <= fld_reg + 3'h1;
                            r_state_reg <= fld_reg == last_reg ? R_CR :
                                           R_TAG;
                        end
                    end
                end
                R_CR: if (ready) begin
                    tx_data_reg <= `CH_CR;
                    tx_go_reg[r_port_reg] <= 1'b1;
                    r_state_reg <= R_IDLE;
                end
                default: r_state_reg <= R_IDLE;
            endcase
        end
    end
endmodule // feeder_serial_command_port

// file: feeder_defs.vh
// Purpose: shared constants of the feeder serial command port
// Assumes: 100 MHz core clock, 8N1 character framing
// Notes:   definitions only, no logic
`ifndef FEEDER_DEFS_VH
`define FEEDER_DEFS_VH

// clock and selectable bit rates
`define CLK_HZ          100000000
`define BAUD_2400       2400
`define BAUD_9600       9600
`define BAUD_19200      19200
`define BAUD_28800      28800
`define BAUD_38400      38400
`define BAUD_57600      57600
`define BAUD_115200     115200
`define RATE_2400       3'h0
`define RATE_9600       3'h1
`define RATE_19200      3'h2
`define RATE_28800      3'h3
`define RATE_38400      3'h4
`define RATE_57600      3'h5
`define RATE_115200     3'h6
`define RATE_DEFAULT    3'h1

// character framing
`define DATA_BITS       4'h8
`define FRAME_BITS      4'hA

// ascii codes used by the frame grammar
`define CH_STX          8'h02
`define CH_CR           8'h0D
`define CH_SET          8'h21
`define CH_QRY          8'h3F
`define CH_ZERO         8'h30
`define CH_NINE         8'h39
`define CH_S            8'h73
`define CH_B            8'h62
`define CH_D            8'h64
`define CH_T            8'h74
`define CH_R            8'h72
`define CH_F            8'h66
`define CH_M            8'h6D
`define CH_C            8'h63
`define CH_K            8'h6B

// argument limits
`define SPEED_MIN       14'h0001
`define SPEED_MAX       14'h0064
`define BATCH_MIN       14'h0001
`define BATCH_MAX       14'h270F
`define DELAY_MAX       14'h0063
`define MAX_DIGITS      3'h4

// setting reset values
`define SPEED_RST       7'h32
`define BATCH_RST       14'h0001
`define DELAY_RST       7'h00

// reply field indices
`define FLD_SPEED       3'h0
`define FLD_BATCH       3'h1
`define FLD_DELAY       3'h2
`define FLD_MISS        3'h3
`define FLD_DOUBLE      3'h4
`define FLD_JOBS        3'h5
`define LAST_DIGIT      3'h4

// cycles to let the key synchroniser settle after reset
`define KEY_SETTLE      3'h4

`endif

// file: uart_link.v
// Purpose: one 8N1 serial port, receive and transmit
// Assumes: rxd arrives from a pin; bit period given in core clocks
// Notes:   framing errors drop the character silently
`timescale 1ns/10ps
`include "feeder_defs.vh"
module uart_link (
    // clock and reset
    input  wire        core_clk,
    input  wire        rstn,
    // bit period in clocks
    input  wire [15:0] bit_div,
    // serial pins
    input  wire        rxd,
    output reg         txd_reg,
    // received byte
    output reg  [7:0]  rx_data_reg,
    output reg         rx_valid_reg,
    // byte to send
    input  wire [7:0]  tx_data,
    input  wire        tx_valid,
    output reg         tx_ready_reg
);
    reg        rx_s1_reg;
    reg        rx_s2_reg;
    reg        rx_busy_reg;
    reg [15:0] rx_cnt_reg;
    reg [3:0]  rx_bit_reg;
    reg [8:0]  rx_sh_reg;
    reg [15:0] tx_cnt_reg;
    reg [3:0]  tx_bit_reg;
    reg [9:0]  tx_sh_reg;

    // receiver: two-stage sync, mid-bit sampling, stop bit check
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rx_s1_reg    <= 1'b1;
            rx_s2_reg    <= 1'b1;
            rx_busy_reg  <= 1'b0;
            rx_cnt_reg   <= 16'h0000;
            rx_bit_reg   <= 4'h0;
            rx_sh_reg    <= 9'h000;
            rx_data_reg  <= 8'h00;
            rx_valid_reg <= 1'b0;
        end else begin
            rx_s1_reg    <= rxd;
            rx_s2_reg    <= rx_s1_reg;
            rx_valid_reg <= 1'b0;
            if (!rx_busy_reg) begin
                if (!rx_s2_reg) begin
                    rx_busy_reg <= 1'b1;
                    rx_cnt_reg  <= {1'b0, bit_div[15:1]}; // half bit
                    rx_bit_reg  <= 4'h0;
                end
            end else if (rx_cnt_reg != 16'h0000) begin
                rx_cnt_reg <= rx_cnt_reg - 16'h0001;
            end else begin
                rx_cnt_reg <= bit_div - 16'h0001;
                if (rx_bit_reg == 4'h0 && rx_s2_reg) begin
                    rx_busy_reg <= 1'b0; // start glitch
                end else if (rx_bit_reg == `FRAME_BITS - 4'h1) begin
                    rx_busy_reg <= 1'b0;
                    rx_data_reg <= rx_sh_reg[8:1];
                    rx_valid_reg <= rx_s2_reg; // 8 data, 1 stop
                end else begin
                    rx_bit_reg <= rx_bit_reg + 4'h1;
                    rx_sh_reg  <= {rx_s2_reg, rx_sh_reg[8:1]};
                end
            end
        end
    end

    // transmitter: start, 8 data lsb first, stop, no parity
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            txd_reg      <= 1'b1;
            tx_ready_reg <= 1'b1;
            tx_cnt_reg   <= 16'h0000;
            tx_bit_reg   <= 4'h0;
            tx_sh_reg    <= 10'h3FF;
        end else if (tx_ready_reg) begin
            if (tx_valid) begin
                tx_ready_reg <= 1'b0;
                tx_sh_reg    <= {1'b1, tx_data, 1'b0};
                tx_bit_reg   <= 4'h0;
                tx_cnt_reg   <= 16'h0000;
            end
        end else if (tx_cnt_reg != 16'h0000) begin
            tx_cnt_reg <= tx_cnt_reg - 16'h0001;
        end else if (tx_bit_reg == `FRAME_BITS) begin
            tx_ready_reg <= 1'b1;
        end else begin
            txd_reg    <= tx_sh_reg[0];
            tx_sh_reg  <= {1'b1, tx_sh_reg[9:1]};
            tx_bit_reg <= tx_bit_reg + 4'h1;
            tx_cnt_reg <= bit_div - 16'h0001;
        end
    end
endmodule // uart_link

// file: feeder_properties.sv
// Purpose: port checks of the feeder command port
// Assumes: one clock, rstn async active low
// Notes:   bound into every instance of the design
`timescale 1ns/10ps
module feeder_properties (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        rstn,
    // serial, menu and events
    input wire logic        prim_rxd,
    input wire logic        prim_txd,
    input wire logic        menu_enter,
    input wire logic        menu_exit,
    input wire logic        miss_event,
    // settings and counters
    input wire logic [6:0]  speed_reg,
    input wire logic [6:0]  delay_reg,
    input wire logic        trigger_reg,
    input wire logic [2:0]  prim_rate_reg,
    input wire logic [2:0]  sec_rate_reg,
    input wire logic [15:0] miss_cnt_reg
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // a strobe lasts one edge only
    sequence strobe_once;
        trigger_reg ##1 !trigger_reg;
    endsequence
    // quiet line and defaults right after reset
    sequence reset_state;
        prim_txd && speed_reg == 7'h32 && delay_reg == 7'h00 &&
        prim_rate_reg == 3'h1 && miss_cnt_reg == 16'h0000;
    endsequence
    trig_pulse_a: assert property (trigger_reg |-> strobe_once)
        else $error("trigger strobe too long");
    reset_vals_a: assert property ($rose(rstn) |-> reset_state)
        else $error("bad state after reset");
    rate_hold_a: assert property ((!menu_enter || menu_exit) |=>
        $stable(prim_rate_reg) && $stable(sec_rate_reg))
        else $error("rate changed without enter");
    rate_legal_a: assert property (prim_rate_reg <= 3'h6 &&
        sec_rate_reg <= 3'h6) else $error("rate code out of range");
    miss_count_a: assert property (miss_event |=>
        miss_cnt_reg == $past(miss_cnt_reg) + 16'h0001 ||
        miss_cnt_reg == 16'h0001) else $error("miss count missed");
    miss_clear_a: assert property (!miss_event |=>
        $stable(miss_cnt_reg) || miss_cnt_reg == 16'h0000)
        else $error("miss count moved");
    arg_range_a: assert property (speed_reg >= 7'h01 &&
        speed_reg <= 7'h64 && delay_reg <= 7'h63)
        else $error("setting out of range");
    // the frame's closing stop bit is still on the line
    frame_end_a: assert property (trigger_reg |-> $past(prim_rxd))
        else $error("trigger without a frame");
endmodule // feeder_properties
bind feeder_serial_command_port feeder_properties chk_u (.core_clk,
    .rstn, .prim_rxd, .prim_txd, .menu_enter, .menu_exit, .miss_event,
    .speed_reg, .delay_reg, .trigger_reg, .prim_rate_reg, .sec_rate_reg,
    .miss_cnt_reg);

// file: host_terminal.sv
// Purpose: terminal on the far side of one serial port
// Assumes: 8N1, lsb first, bit period in clocks
// Notes:   line idles high, as the port's own idle level
`timescale 1ns/10ps
module host_terminal (
    // clock
    input  wire logic        core_clk,
    // lines seen from the terminal
    output logic             txd_out,
    input  wire logic        rxd_in,
    // bit period in clocks
    input  wire logic [15:0] bit_clks
);
    logic [7:0] got [$];
    initial txd_out = 1'b1;
    // start, 8 data, stop; no flow control
    task automatic send(logic [7:0] b);
        logic [9:0] f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge core_clk) #1;
            txd_out = f[i];
            repeat (bit_clks - 1) @(posedge core_clk);
        end
    endtask
    // mid-bit sampling; a low stop bit drops the character
    initial forever begin : rx_p
        logic [8:0] r;
        @(negedge rxd_in);
        repeat (bit_clks / 2) @(posedge core_clk);
        for (int i = 0; i < 9; i++) begin
            repeat (bit_clks) @(posedge core_clk);
            r[i] = rxd_in;
        end
        if (r[8]) got.push_back(r[7:0]);
    end
endmodule // host_terminal

// file: tb_top.sv
// Purpose: self-checking bench of the feeder command port
// Assumes: CLK_HZ scaled so a 115200 bit is 10 clocks
// Notes:   secondary input idles high, it is not exercised
`timescale 1ns/10ps
module tb_top;
    logic        core_clk, rstn, prim_rxd, prim_txd, key, ev, trig;
    logic        m_sel, m_port, m_ent, m_exit, trig_seen;
    logic [2:0]  m_rate, p_rate, s_rate;
    logic [6:0]  speed, delay;
    logic [15:0] bit_clks, miss, dbl, jobs;
    int          miscompares = 0, num_checks = 0;
    feeder_serial_command_port #(.CLK_HZ(1152000)) dut_u (
        .core_clk(core_clk), .rstn(rstn), .prim_rxd(prim_rxd),
        .prim_txd(prim_txd), .sec_rxd(1'b1), .sec_txd(),
        .menu_select(m_sel), .menu_port(m_port), .menu_rate(m_rate),
        .menu_enter(m_ent), .menu_exit(m_exit), .cycle_key(key),
        .miss_event(ev), .double_event(ev), .batch_done(ev),
        .speed_reg(speed), .batch_reg(), .delay_reg(delay),
        .trigger_reg(trig), .rstop_reg(), .feeder_reset_reg(),
        .prim_rate_reg(p_rate), .sec_rate_reg(s_rate),
        .miss_cnt_reg(miss), .double_cnt_reg(dbl), .jobs_cnt_reg(jobs));
    host_terminal host (.core_clk(core_clk), .txd_out(prim_rxd),
        .rxd_in(prim_txd), .bit_clks(bit_clks));
    always @(posedge core_clk) if (trig === 1'b1) trig_seen <= 1'b1;
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic frame(string s);
        host.send(8'h02);
        foreach (s[i]) host.send(s[i]);
        host.send(8'h0D);
        repeat (8) @(posedge core_clk);
    endtask
    // bounded wait, then compare char by char
    task automatic reply(string s);
        for (int n = 0; n < 60000 && host.got.size() < s.len(); n++)
            @(posedge core_clk);
        foreach (s[i]) check("reply", host.got.size() > i ?
            host.got[i] : 8'hXX, s[i]);
        host.got.delete();
        #1;
    endtask
    task automatic menu(logic p, logic [2:0] r, logic ent);
        {m_port, m_rate, m_sel} = {p, r, 1'b1};
        @(posedge core_clk) #1;
        {m_sel, m_ent, m_exit} = {1'b0, ent, !ent};
        @(posedge core_clk) #1;
        {m_ent, m_exit} = 2'h0;
        @(posedge core_clk) #1;
    endtask
    task automatic t_dump;
        reply("s00050b00001d00000m00000k00000t00000\015");
        key = 1'b0;
    endtask
    task automatic t_menu;
        menu(1'b0, 3'h6, 1'b0);
        check("prim rate kept", p_rate, 3'h1);
        menu(1'b0, 3'h6, 1'b1);
        for (int r = 0; r < 7; r++) begin
            menu(1'b1, r[2:0], 1'b1);
            check("rates", {p_rate, s_rate}, {3'h6, r[2:0]});
        end
        bit_clks = 16'h000A;
    endtask
    // good set, out-of-range set, malformed frame
    task automatic t_set;
        frame("s!55");
        frame("s!101");
        frame("s55");
        frame("d!99");
        frame("b!250");
        frame("t!");
        check("speed", speed, 7'h37);
        check("delay", delay, 7'h63);
        check("trigger", trig_seen, 1'b1);
        frame("?!");
        reply("s00055b00250d00099\015");
    endtask
    task automatic t_count;
        repeat (14) begin
            ev = !ev; // seven one-cycle pulses, one idle cycle between
            @(posedge core_clk) #1;
        end
        frame("mc?");
        reply("m00007\015");
        frame("mc!");
        check("miss clear", {miss, dbl}, 32'h7);
        frame("dc!");
        frame("tc!");
        check("other clears", dbl | jobs, 16'h0);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        {rstn, ev, m_sel, m_port, m_ent, m_exit, trig_seen, key} = 8'h01;
        m_rate = 3'h0;
        bit_clks = 16'h0078;
        repeat (2) @(posedge core_clk) #1;
        rstn = 1'b1;
        t_dump;
        t_menu;
        t_set;
        t_count;
        finish_test;
    end
    initial begin
        #1000000;
        miscompares++;
        finish_test;
    end
endmodule // tb_top
